//--- inc/usart_pkg.sv
// Purpose: shared constants and types for the serial transceiver core
// Assumes: one system clock, frame format shared by both directions
// Notes:   frame positions count from 0 at the start bit
package usart_pkg;
	// ==========================================================
	// widths and line levels
	localparam int       DIV_W     = 12;
	localparam int       POS_W     = 4;
	localparam logic     TXD_IDLE  = 1'b1;
	localparam logic     START_BIT = 1'b0;
	localparam logic     STOP_BIT  = 1'b1;
	// ==========================================================
	// sample counts per bit, stored as count minus one, then the mid-bit sample index for each speed
	localparam logic [3:0] DIV_NORM = 4'hf;
	localparam logic [3:0] DIV_DS   = 4'h7;
	localparam logic [3:0] MID_NORM = 4'h7;
	localparam logic [3:0] MID_DS   = 4'h3;
	// ==========================================================
	// frame format encodings
	localparam logic [2:0] CS_9BIT  = 3'h7;
	localparam logic [3:0] CS_BASE  = 4'h5;
	localparam logic [3:0] DATA_MAX = 4'h9;
	localparam logic [3:0] DATA_DEF = 4'h8;
	localparam int         PM_EN    = 1;
	localparam int         PM_ODD   = 0;
	localparam logic [8:0] MASK_ALL = 9'h1ff;

	typedef struct packed {
		logic [2:0] char_size;
		logic [1:0] parity_mode;
		logic       stop_bit_select;
	} frame_fmt_s;

	typedef enum logic {TX_IDLE, TX_BUSY} tx_state_e;
	typedef enum logic {RX_IDLE, RX_BUSY} rx_state_e;
endpackage

//--- src/usart_core.sv
// Purpose: clock generation and frame formatting of a serial transceiver
// Assumes: config inputs held steady while frames are in flight
// Notes:   rxd and the external clock pass a three-stage filter
`timescale 1ns/10ps
module usart_core #(
	parameter int DIV_W = usart_pkg::DIV_W
) (
	// clock, reset, enable
	input  wire logic               clk_in,
	input  wire logic               srst_in,
	input  wire logic               en_in,
	// configuration
	input  wire logic               sync_mode_select_in,
	input  wire logic               double_speed_in,
	input  wire logic               ext_clock_pin_direction_in,
	input  wire logic               sync_clock_polarity_in,
	input  wire logic [DIV_W-1:0]   baud_divisor_in,
	input  wire logic               baud_divisor_low_wr_in,
	input  wire usart_pkg::frame_fmt_s fmt_in,
	// transmit stream
	input  wire logic [7:0]         tx_data_in,
	input  wire logic               tx_ninth_bit_in,
	input  wire logic               tx_valid_in,
	output logic                    tx_ready_out,
	// receive stream
	output logic [8:0]              rx_data_out,
	output logic                    rx_valid_out,
	output logic                    frame_error_out,
	output logic                    parity_error_out,
	// serial pins
	input  wire logic               rxd_in,
	output logic                    txd_out,
	input  wire logic               sync_clock_pin_in,
	output logic                    sync_clock_pin_out,
	output logic                    sync_clock_pin_oe_out
);
	if (DIV_W < 1 || DIV_W > 16) begin
		$error("DIV_W out of range");
	end

	// ==========================================================
	// pin filters, baud generator, sync clock
	logic [DIV_W-1:0] cnt_ff, nxt_cnt;
	logic [2:0]       rxd_s_ff, xck_s_ff;
	logic             rxd_f_ff, nxt_rxd_f, xck_f_ff, nxt_xck_f;
	logic             mck_ff, nxt_mck, raw_prev_ff, pin_ff, nxt_pin, oe_ff;
	logic             tick, master, raw, chg_edge, smp_edge;
	logic [3:0]       sdiv, smid;

	assign master = sync_mode_select_in & ext_clock_pin_direction_in;
	assign tick   = (cnt_ff == '0);
	assign sdiv   = double_speed_in ? usart_pkg::DIV_DS : usart_pkg::DIV_NORM;
	assign smid   = double_speed_in ? usart_pkg::MID_DS : usart_pkg::MID_NORM;
	// both modes share one internal phase: rising is the change edge
	assign raw      = master ? mck_ff : (xck_f_ff ^ sync_clock_polarity_in);
	assign chg_edge = sync_mode_select_in & raw & ~raw_prev_ff;
	assign smp_edge = sync_mode_select_in & ~raw & raw_prev_ff;
	usart_pkg::tx_state_e tx_state_ff, nxt_tx_state;

	always_comb begin
		nxt_cnt = cnt_ff - 1'b1;
		if (baud_divisor_low_wr_in || tick) begin
			nxt_cnt = baud_divisor_in;
		end
		// only a value seen twice in a row is believed
		nxt_rxd_f = (rxd_s_ff[1] == rxd_s_ff[2]) ? rxd_s_ff[2] : rxd_f_ff;
		nxt_xck_f = (xck_s_ff[1] == xck_s_ff[2]) ? xck_s_ff[2] : xck_f_ff;
		nxt_mck = mck_ff;
		// master clock halts low between frames so the pin rests at polarity
		if (!master) begin
			nxt_mck = 1'b0;
		end else if (tick && (mck_ff || tx_valid_in || tx_state_ff == usart_pkg::TX_BUSY)) begin
			nxt_mck = ~mck_ff;
		end
		nxt_pin = nxt_mck ^ sync_clock_polarity_in;
	end
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			cnt_ff      <= '0;
			rxd_s_ff    <= '1;
			xck_s_ff    <= '0;
			rxd_f_ff    <= usart_pkg::TXD_IDLE;
			xck_f_ff    <= 1'b0;
			mck_ff      <= 1'b0;
			raw_prev_ff <= 1'b0;
			pin_ff      <= 1'b0;
			oe_ff       <= 1'b0;
		end else if (en_in) begin
			cnt_ff      <= nxt_cnt;
			rxd_s_ff    <= {rxd_s_ff[1:0], rxd_in};
			xck_s_ff    <= {xck_s_ff[1:0], sync_clock_pin_in};
			rxd_f_ff    <= nxt_rxd_f;
			xck_f_ff    <= nxt_xck_f;
			mck_ff      <= nxt_mck;
			raw_prev_ff <= raw;
			pin_ff      <= nxt_pin;
			oe_ff       <= master;
		end
	end

	// ==========================================================
	// frame format decode, shared by both directions
	logic [3:0] nbits, last_pos;
	logic       par_en, par_odd;
	logic [8:0] dmask;

	always_comb begin
		if (fmt_in.char_size == usart_pkg::CS_9BIT) begin
			nbits = usart_pkg::DATA_MAX;
		end else if (fmt_in.char_size[2]) begin
			nbits = usart_pkg::DATA_DEF;
		end else begin
			nbits = usart_pkg::CS_BASE + {1'b0, fmt_in.char_size};
		end
		par_en   = fmt_in.parity_mode[usart_pkg::PM_EN];
		par_odd  = fmt_in.parity_mode[usart_pkg::PM_ODD];
		// positions: 0 start, 1..n data, parity, then one or two stops
		last_pos = nbits + {3'h0, par_en} + 4'h1 + {3'h0, fmt_in.stop_bit_select};
		dmask    = usart_pkg::MASK_ALL >> (usart_pkg::DATA_MAX - nbits);
	end

	// ==========================================================
	// transmitter
	logic [8:0] tx_sh_ff, nxt_tx_sh;
	logic [3:0] tx_pos_ff, nxt_tx_pos, tx_pre_ff, nxt_tx_pre;
	logic       tx_par_ff, nxt_tx_par, txd_ff, nxt_txd, rdy_ff, nxt_rdy;
	logic       tx_step, accept;

	// sync modes step on the change edge, async every sdiv+1 ticks
	assign tx_step = sync_mode_select_in ? chg_edge : (tick && tx_pre_ff == sdiv);
	assign accept  = tx_step && rdy_ff && tx_valid_in;

	always_comb begin
		nxt_tx_state = tx_state_ff;
		nxt_tx_sh    = tx_sh_ff;
		nxt_tx_pos   = tx_pos_ff;
		nxt_tx_par   = tx_par_ff;
		nxt_tx_pre   = tx_pre_ff;
		if (tick) begin
			nxt_tx_pre = (tx_pre_ff == sdiv) ? 4'h0 : tx_pre_ff + 4'h1;
		end
		if (accept) begin
			// a waiting word starts right after the last stop bit
			nxt_tx_state = usart_pkg::TX_BUSY;
			nxt_tx_sh    = {tx_ninth_bit_in, tx_data_in};
			nxt_tx_pos   = '0;
			nxt_tx_par   = ^({tx_ninth_bit_in, tx_data_in} & dmask) ^ par_odd;
		end else if (tx_step && tx_state_ff == usart_pkg::TX_BUSY) begin
			if (tx_pos_ff == last_pos) begin
				nxt_tx_state = usart_pkg::TX_IDLE;
			end else begin
				nxt_tx_pos = tx_pos_ff + 4'h1;
			end
		end
		nxt_rdy = (nxt_tx_state == usart_pkg::TX_IDLE) || (nxt_tx_pos == last_pos);
		if (nxt_tx_state == usart_pkg::TX_IDLE) begin
			nxt_txd = usart_pkg::TXD_IDLE;
		end else if (nxt_tx_pos == 4'h0) begin
			nxt_txd = usart_pkg::START_BIT;
		end else if (nxt_tx_pos <= nbits) begin
			nxt_txd = nxt_tx_sh[nxt_tx_pos - 4'h1];
		end else if (par_en && nxt_tx_pos == nbits + 4'h1) begin
			nxt_txd = nxt_tx_par;
		end else begin
			nxt_txd = usart_pkg::STOP_BIT;
		end
	end
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			tx_state_ff <= usart_pkg::TX_IDLE;
			tx_sh_ff    <= '0;
			tx_pos_ff   <= '0;
			tx_par_ff   <= 1'b0;
			tx_pre_ff   <= '0;
			txd_ff      <= usart_pkg::TXD_IDLE;
			rdy_ff      <= 1'b1;
		end else if (en_in) begin
			tx_state_ff <= nxt_tx_state;
			tx_sh_ff    <= nxt_tx_sh;
			tx_pos_ff   <= nxt_tx_pos;
			tx_par_ff   <= nxt_tx_par;
			tx_pre_ff   <= nxt_tx_pre;
			txd_ff      <= nxt_txd;
			rdy_ff      <= nxt_rdy;
		end
	end

	// ==========================================================
	// receiver
	usart_pkg::rx_state_e rx_state_ff, nxt_rx_state;
	logic [8:0] rx_sh_ff, nxt_rx_sh, rx_dat_ff, nxt_rx_dat;
	logic [3:0] rx_pos_ff, nxt_rx_pos, rx_smp_ff, nxt_rx_smp;
	logic       rx_par_ff, nxt_rx_par, rxv_ff, nxt_rxv;
	logic       fe_ff, nxt_fe, pe_ff, nxt_pe, rx_samp;

	// async samples once mid-bit from the tick stream; sync on sample edge
	assign rx_samp = sync_mode_select_in ? smp_edge : (tick && rx_smp_ff == smid);

	always_comb begin
		nxt_rx_state = rx_state_ff;
		nxt_rx_sh    = rx_sh_ff;
		nxt_rx_pos   = rx_pos_ff;
		nxt_rx_smp   = rx_smp_ff;
		nxt_rx_par   = rx_par_ff;
		nxt_rx_dat   = rx_dat_ff;
		nxt_fe       = fe_ff;
		nxt_pe       = pe_ff;
		nxt_rxv      = 1'b0;
		if (tick) begin
			nxt_rx_smp = (rx_smp_ff >= sdiv) ? 4'h0 : rx_smp_ff + 4'h1;
		end
		if (rx_state_ff == usart_pkg::RX_IDLE) begin
			nxt_rx_par = par_odd;
			if (!sync_mode_select_in && rxd_f_ff == usart_pkg::START_BIT) begin
				nxt_rx_state = usart_pkg::RX_BUSY;
				nxt_rx_pos   = 4'h0;
				nxt_rx_smp   = 4'h0;
			end else if (smp_edge && rxd_f_ff == usart_pkg::START_BIT) begin
				nxt_rx_state = usart_pkg::RX_BUSY;
				nxt_rx_pos   = 4'h1;
			end
		end else if (rx_samp) begin
			nxt_rx_pos = rx_pos_ff + 4'h1;
			if (rx_pos_ff == 4'h0) begin
				// a start bit gone high by mid-bit was only a glitch
				if (rxd_f_ff != usart_pkg::START_BIT) begin
					nxt_rx_state = usart_pkg::RX_IDLE;
				end
			end else if (rx_pos_ff <= nbits) begin
				nxt_rx_sh  = {rxd_f_ff, rx_sh_ff[8:1]};
				nxt_rx_par = rx_par_ff ^ rxd_f_ff;
			end else if (par_en && rx_pos_ff == nbits + 4'h1) begin
				nxt_rx_par = rx_par_ff ^ rxd_f_ff;
			end else begin
				// first stop ends the frame; a second stop is never looked at
				nxt_rx_state = usart_pkg::RX_IDLE;
				nxt_fe       = (rxd_f_ff != usart_pkg::STOP_BIT);
				nxt_pe       = par_en & rx_par_ff;
				nxt_rx_dat   = rx_sh_ff >> (usart_pkg::DATA_MAX - nbits);
				nxt_rxv      = 1'b1;
			end
		end
	end
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			rx_state_ff <= usart_pkg::RX_IDLE;
			rx_sh_ff    <= '0;
			rx_pos_ff   <= '0;
			rx_smp_ff   <= '0;
			rx_par_ff   <= 1'b0;
			rx_dat_ff   <= '0;
			fe_ff       <= 1'b0;
			pe_ff       <= 1'b0;
			rxv_ff      <= 1'b0;
		end else if (en_in) begin
			rx_state_ff <= nxt_rx_state;
			rx_sh_ff    <= nxt_rx_sh;
			rx_pos_ff   <= nxt_rx_pos;
			rx_smp_ff   <= nxt_rx_smp;
			rx_par_ff   <= nxt_rx_par;
			rx_dat_ff   <= nxt_rx_dat;
			fe_ff       <= nxt_fe;
			pe_ff       <= nxt_pe;
			rxv_ff      <= nxt_rxv;
		end
	end

	assign tx_ready_out          = rdy_ff;
	assign txd_out               = txd_ff;
	assign rx_data_out           = rx_dat_ff;
	assign rx_valid_out          = rxv_ff;
	assign frame_error_out       = fe_ff;
	assign parity_error_out      = pe_ff;
	assign sync_clock_pin_out    = pin_ff;
	assign sync_clock_pin_oe_out = oe_ff;

	// ==========================================================
	// checks
	default clocking dc @(posedge clk_in); endclocking
	default disable iff (srst_in || !en_in);

	AST_RELOAD_ON_WRITE: assert property (
		baud_divisor_low_wr_in |=> cnt_ff == $past(baud_divisor_in))
		else $error("divisor write did not reload counter");
	AST_TICK_AT_ZERO: assert property (
		cnt_ff == 1 && !baud_divisor_low_wr_in |=> tick)
		else $error("no tick when counter reached zero");
	AST_START_LOW: assert property (
		tx_state_ff == usart_pkg::TX_BUSY && tx_pos_ff == 4'h0 |-> !txd_out)
		else $error("start bit not low");
	AST_IDLE_HIGH: assert property (
		tx_state_ff == usart_pkg::TX_IDLE |-> txd_out)
		else $error("idle line not high");
	AST_PIN_ASYNC_OFF: assert property (
		!sync_mode_select_in |=> !sync_clock_pin_oe_out)
		else $error("clock pin driven in async mode");
	AST_MASTER_DRIVES: assert property (
		master |=> sync_clock_pin_oe_out)
		else $error("master not driving clock pin");
	AST_PARITY_SLOT: assert property (
		tx_state_ff == usart_pkg::TX_BUSY && par_en && tx_pos_ff == nbits + 4'h1
		|-> txd_out == tx_par_ff)
		else $error("parity slot carries wrong bit");
	AST_EDGES_APART: assert property (
		chg_edge |-> !smp_edge ##1 !chg_edge)
		else $error("change and sample edges collide");
	AST_DS_EIGHT: assert property (
		!sync_mode_select_in && double_speed_in && tick |=> rx_smp_ff <= usart_pkg::DIV_DS)
		else $error("double speed uses more than 8 samples");
	COV_PARITY_FRAME: cover property (accept && par_en);
	COV_FRAME_ERROR: cover property (rx_valid_out && frame_error_out);
	COV_MASTER_STEP: cover property (master && tx_step);
endmodule

//--- sim/remote_serial.sv
// Purpose: remote serial transceiver facing the data lines
// Assumes: asynchronous framing, bit length given in system clock cycles
// Notes:   the line rests high between frames
`timescale 1ns/10ps
module remote_serial (
	input  wire logic clk_in,
	input  wire logic txd_in,
	output logic      rxd_out
);
	// ==========================================================
	// frame drive and capture
	int bit_cycles = 32;
	initial rxd_out = 1'b1;
	// one bit at a time, for links clocked from outside
	task automatic drive(input logic v);
		rxd_out <= v;
	endtask
	task automatic send(input logic [12:0] bits, input int n);
		for (int i = 0; i < n; i++) begin
			rxd_out <= bits[i];
			repeat (bit_cycles) @(posedge clk_in);
		end
		rxd_out <= 1'b1;
	endtask
	// samples at mid-bit so a small launch skew does not matter
	task automatic capture(input int n, output logic [12:0] bits);
		bits = '0;
		wait (txd_in === 1'b0);
		repeat (bit_cycles / 2) @(posedge clk_in);
		for (int i = 0; i < n; i++) begin
			bits[i] = txd_in;
			repeat (bit_cycles) @(posedge clk_in);
		end
	endtask
endmodule

//--- sim/test_usart_core.sv
// Purpose: self-checking bench for the serial transceiver core
// Assumes: divisor 1, so one tick every two system clocks
// Notes:   frame bits are compared lsb first from the start bit
`timescale 1ns/10ps
module test_usart_core;
	// ==========================================================
	// stimulus signals
	logic clk_in, srst_in, en_in, sync_mode_select_in, double_speed_in;
	logic ext_clock_pin_direction_in, sync_clock_polarity_in, baud_divisor_low_wr_in;
	logic [11:0] baud_divisor_in;
	usart_pkg::frame_fmt_s fmt_in;
	logic [7:0] tx_data_in;
	logic tx_ninth_bit_in, tx_valid_in, tx_ready_out, rx_valid_out, frame_error_out;
	logic [8:0] rx_data_out;
	logic parity_error_out, rxd_in, txd_out, sync_clock_pin_in;
	logic sync_clock_pin_out, sync_clock_pin_oe_out;
	int fails = 0;
	int n_tests = 0;
	usart_core usart_core_i (.clk_in, .srst_in, .en_in, .sync_mode_select_in,
		.double_speed_in, .ext_clock_pin_direction_in, .sync_clock_polarity_in,
		.baud_divisor_in, .baud_divisor_low_wr_in, .fmt_in, .tx_data_in,
		.tx_ninth_bit_in, .tx_valid_in, .tx_ready_out, .rx_data_out, .rx_valid_out,
		.frame_error_out, .parity_error_out, .rxd_in, .txd_out, .sync_clock_pin_in,
		.sync_clock_pin_out, .sync_clock_pin_oe_out);
	remote_serial remote_serial_i (.clk_in(clk_in), .txd_in(txd_out), .rxd_out(rxd_in));
	// ==========================================================
	// helpers
	task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	function automatic logic [12:0] frame_bits(input usart_pkg::frame_fmt_s f,
		input logic [8:0] d, output int n, output int nb);
		logic [12:0] b;
		logic p;
		nb = (f.char_size == usart_pkg::CS_9BIT) ? 9 : (f.char_size < 3'h4) ?
			int'(f.char_size) + 5 : 8;
		b = '0;
		p = f.parity_mode[usart_pkg::PM_ODD];
		for (int i = 0; i < nb; i++) begin
			b[i + 1] = d[i];
			p ^= d[i];
		end
		n = nb + 1;
		if (f.parity_mode[usart_pkg::PM_EN]) begin
			b[n] = p;
			n++;
		end
		b[n] = 1'b1;
		b[n + 1] = f.stop_bit_select;
		n += 1 + int'(f.stop_bit_select);
		return b;
	endfunction
	// the counter is reloaded on every mode change so ticks restart cleanly
	task automatic cfg(input logic sm, ds, dir, pol, input int bitc);
		sync_mode_select_in <= sm;
		double_speed_in <= ds;
		ext_clock_pin_direction_in <= dir;
		sync_clock_polarity_in <= pol;
		baud_divisor_low_wr_in <= 1'b1;
		remote_serial_i.bit_cycles = bitc;
		@(posedge clk_in);
		baud_divisor_low_wr_in <= 1'b0;
		repeat (8) @(posedge clk_in);
		check_val(16'(sync_clock_pin_oe_out), 16'(sm & dir));
	endtask
	// ==========================================================
	// scenarios
	task automatic test_tx(input usart_pkg::frame_fmt_s f, input logic [8:0] d);
		logic [12:0] exp, got;
		int n, nb;
		exp = frame_bits(f, d, n, nb);
		fmt_in <= f;
		tx_data_in <= d[7:0];
		tx_ninth_bit_in <= d[8];
		repeat (4) @(posedge clk_in);
		fork
			remote_serial_i.capture(n, got);
			begin
				tx_valid_in <= 1'b1;
				for (int k = 0; k < 100 && tx_ready_out !== 1'b0; k++) @(posedge clk_in);
				tx_valid_in <= 1'b0;
			end
		join
		check_val(16'(got), 16'(exp));
	endtask
	// mode: 0 clean, 1 bad parity, 2 first stop low, 3 second stop low
	task automatic test_rx(input usart_pkg::frame_fmt_s f, input logic [8:0] d, input int mode);
		logic [12:0] b;
		logic seen;
		int n, nb, k;
		b = frame_bits(f, d, n, nb);
		k = n - 1 - int'(f.stop_bit_select);
		if (mode > 0)
			b[k + mode - 2] = ~b[k + mode - 2];
		fmt_in <= f;
		repeat (4) @(posedge clk_in);
		fork
			remote_serial_i.send(b, n);
			for (k = 0; k < 600 && rx_valid_out !== 1'b1; k++) @(posedge clk_in);
		join
		seen = (k < 600);
		check_val(16'(seen), 16'h0001);
		check_val(16'(rx_data_out), 16'(d & ((9'h1 << nb) - 9'h1)));
		check_val(16'(frame_error_out), 16'(mode == 2));
		check_val(16'(parity_error_out), 16'(mode == 1));
		// a low stop bit reads as a fresh start; let that false frame run out
		if (mode >= 2)
			repeat (16 * remote_serial_i.bit_cycles) @(posedge clk_in);
	endtask
	// the far side samples where the pin returns to its idle level
	task automatic test_sync(input logic pol);
		logic [12:0] exp, got;
		logic prev;
		int n, nb, i;
		cfg(1'b1, 1'b0, 1'b1, pol, 32);
		check_val(16'(sync_clock_pin_out), 16'(pol));
		exp = frame_bits('{3'h3, 2'h0, 1'b0}, 9'h096, n, nb);
		fmt_in <= '{3'h3, 2'h0, 1'b0};
		tx_data_in <= 8'h96;
		tx_valid_in <= 1'b1;
		got = '0;
		i = 0;
		prev = sync_clock_pin_out;
		for (int k = 0; k < 400 && i < n; k++) begin
			@(posedge clk_in);
			if (prev !== sync_clock_pin_out && sync_clock_pin_out === pol &&
				(i > 0 || txd_out === 1'b0)) begin
				got[i] = txd_out;
				i++;
			end
			if (tx_ready_out === 1'b0)
				tx_valid_in <= 1'b0;
			prev = sync_clock_pin_out;
		end
		check_val(16'(got), 16'(exp));
	endtask
	// slave clock period of 16 system clocks leaves room for the input filter delay
	task automatic test_slave(input logic pol);
		logic [12:0] exp, got, rxb;
		int n, nb;
		sync_clock_pin_in <= pol;
		cfg(1'b1, 1'b0, 1'b0, pol, 32);
		exp = frame_bits('{3'h3, 2'h0, 1'b0}, 9'h0c6, n, nb);
		rxb = frame_bits('{3'h3, 2'h0, 1'b0}, 9'h039, n, nb);
		fmt_in <= '{3'h3, 2'h0, 1'b0};
		tx_data_in <= 8'hc6;
		tx_valid_in <= 1'b1;
		got = '0;
		for (int i = 0; i < n; i++) begin
			sync_clock_pin_in <= ~pol;
			remote_serial_i.drive(rxb[i]);
			repeat (8) @(posedge clk_in);
			got[i] = txd_out;
			sync_clock_pin_in <= pol;
			if (tx_ready_out === 1'b0)
				tx_valid_in <= 1'b0;
			repeat (8) @(posedge clk_in);
		end
		check_val(16'(got), 16'(exp));
		check_val(16'(rx_data_out), 16'h0039);
		check_val(16'(frame_error_out), 16'h0000);
	endtask
	// ==========================================================
	// main sequence
	initial begin
		clk_in = 1'b0;
		forever #20 clk_in = ~clk_in;
	end
	initial begin
		repeat (80000) @(posedge clk_in);
		fails++;
		complete_run();
	end
	initial begin
		logic [2:0] cs_tab [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7};
		usart_pkg::frame_fmt_s f;
		{srst_in, en_in, sync_mode_select_in, double_speed_in} = 4'hc;
		{ext_clock_pin_direction_in, sync_clock_polarity_in, baud_divisor_low_wr_in} = 3'h0;
		{tx_ninth_bit_in, tx_valid_in, sync_clock_pin_in} = 3'h0;
		baud_divisor_in = 12'h001;
		fmt_in = '{3'h3, 2'h0, 1'b0};
		tx_data_in = 8'h00;
		repeat (12) @(posedge clk_in);
		srst_in <= 1'b0;
		@(posedge clk_in);
		check_val(16'({txd_out, tx_ready_out, rx_valid_out, sync_clock_pin_oe_out}), 16'hc);
		cfg(1'b0, 1'b0, 1'b0, 1'b0, 32);
		for (int i = 0; i < 30; i++) begin
			f = '{cs_tab[i / 6], (i % 3 == 0) ? 2'h0 : 2'((i % 3) + 1), 1'(i / 3 % 2)};
			test_tx(f, 9'h1a5 ^ 9'(i * 37));
			test_rx(f, 9'h05a ^ 9'(i * 29), 0);
		end
		for (int m = 1; m < 4; m++)
			test_rx('{3'h3, 2'h2, 1'b1}, 9'h0c3, m);
		cfg(1'b0, 1'b1, 1'b0, 1'b0, 16);
		test_tx('{3'h3, 2'h3, 1'b0}, 9'h03c);
		test_rx('{3'h7, 2'h2, 1'b0}, 9'h1e1, 0);
		test_sync(1'b0);
		test_sync(1'b1);
		test_slave(1'b0);
		test_slave(1'b1);
		complete_run();
	end
endmodule
